// ===== hdl/rsie_pkg.sv
// constants for the rotate / sleep execution block
// assumes a 32-bit APB slave port and a 32-entry file of 8-bit registers
package rsie_pkg;

  // apb register offsets (byte addresses)
  localparam logic [7:0] RSIE_OFS_INSTR = 8'h00;
  localparam logic [7:0] RSIE_OFS_WREG = 8'h04;
  localparam logic [7:0] RSIE_OFS_STATUS = 8'h08;
  localparam logic [7:0] RSIE_OFS_WDOG = 8'h0C;
  localparam logic [7:0] RSIE_OFS_PRESC = 8'h10;
  localparam logic [7:0] RSIE_OFS_FADDR = 8'h14;
  localparam logic [7:0] RSIE_OFS_FDATA = 8'h18;
  localparam logic [7:0] RSIE_OFS_WAKE = 8'h1C;

  // instruction word fields
  localparam int RSIE_OP_HI = 11;
  localparam int RSIE_OP_LO = 6;
  localparam int RSIE_DEST_BIT = 5;
  localparam int RSIE_FSEL_HI = 4;
  localparam logic [5:0] RSIE_OPC_ROT_LEFT = 6'h0D;
  localparam logic [5:0] RSIE_OPC_ROT_RIGHT = 6'h0C;
  localparam logic [11:0] RSIE_OPC_SLEEP = 12'h003;

  // status register bit positions
  localparam int RSIE_ST_CARRY = 0;
  localparam int RSIE_ST_SLEEP_N = 3;
  localparam int RSIE_ST_EXPIRY_N = 4;
  localparam int RSIE_ST_WAKE = 7;

  // values after reset, and the counter clears done by sleep
  localparam logic [7:0] RSIE_W_RST = 8'h00;
  localparam logic [4:0] RSIE_FADDR_RST = 5'h00;
  localparam logic RSIE_CARRY_RST = 1'b0;
  localparam logic RSIE_EXPIRY_N_RST = 1'b1;
  localparam logic RSIE_SLEEP_N_RST = 1'b1;
  localparam logic RSIE_WAKE_RST = 1'b0;
  localparam logic [7:0] RSIE_WDOG_RST = 8'h00;
  localparam logic [7:0] RSIE_PRESC_RST = 8'h00;
  localparam logic [7:0] RSIE_WDOG_CLEAR = 8'h00;
  localparam logic [7:0] RSIE_PRESC_CLEAR = 8'h00;

  // bus handshake states, one bit flips per step except done back to idle
  typedef enum logic [1:0]
  {
    RSIE_BUS_IDLE = 2'b00,
    RSIE_BUS_WAIT = 2'b01,
    RSIE_BUS_DONE = 2'b11
  } rsie_bus_e;

endpackage

// ===== hdl/rsie_rotate.sv
// one-bit rotate through carry, left or right
// assumes a purely combinational use by the execution block
`timescale 1ns/1ns
module rsie_rotate #(
  parameter int DATA_W = 8
)(
  // operand
  input wire logic [DATA_W-1:0] data_in,
  input wire logic carry_in,
  input wire logic rot_left,
  // result
  output logic [DATA_W-1:0] data_out,
  output logic carry_out
);

  always_comb
  begin
    if (rot_left)
    begin
      data_out = {data_in[DATA_W-2:0], carry_in};
      carry_out = data_in[DATA_W-1];
    end
    else
    begin
      data_out = {carry_in, data_in[DATA_W-1:1]};
      carry_out = data_in[0];
    end
  end

endmodule

// ===== hdl/rsie_file_mem.sv
// file register storage, one write port and one registered read port
// assumes the read address is held for one cycle before data is used
`timescale 1ns/1ns
module rsie_file_mem #(
  parameter int DATA_W = 8,
  parameter int DEPTH = 32,
  parameter int ADDR_W = 5
)(
  // clock
  input wire logic clk,
  // write side
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  // read side
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data_r
);

  logic [DATA_W-1:0] mem [DEPTH];

  // no reset: contents are undefined until software writes them
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule

// ===== hdl/rsie_core.sv
// execution of rotate-left, rotate-right (through carry) and sleep
// assumes an apb master on CLK_SYS; opcodes arrive as writes to the
// instruction register and run at the completing edge of that write
//
// Contract
// [RQ1] rotate-left: shift file reg left, old carry into bit 0, bit 7 to carry
// [RQ2] rotate-right: shift file reg right, old carry into bit 7, bit 0 to carry
// [RQ3] rotate result goes to working reg if dest bit 0, else file reg
// [RQ4] sleep sets the time-out status bit to one
// [RQ5] sleep clears power-down status bit, pin-change wake flag untouched
// [RQ6] sleep zeroes the watchdog counter and its prescaler
// [RQ7] after sleep, execution halts and the main oscillator stops
// [RQ8] each of these opcodes is one word and completes in one cycle
`timescale 1ns/1ns
module rsie_core
#(
  parameter int DATA_W = 8,
  parameter int FILE_DEPTH = 32,
  parameter int FILE_AW = 5
)(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // power state
  output logic SLEEP_ACTIVE,
  output logic OSC_RUN
);

  import rsie_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations

  rsie_bus_e bus_r;
  rsie_bus_e bus_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;

  logic [DATA_W-1:0] w_r;
  logic [DATA_W-1:0] w_nxt;
  logic carry_r;
  logic carry_nxt;
  logic watchdog_expiry_flag_n_r;
  logic watchdog_expiry_flag_n_nxt;
  logic sleep_entered_flag_n_r;
  logic sleep_entered_flag_n_nxt;
  logic pin_change_wake_flag_r;
  logic pin_change_wake_flag_nxt;
  logic sleep_r;
  logic sleep_nxt;
  logic osc_run_r;
  logic osc_run_nxt;
  logic [FILE_AW-1:0] faddr_r;
  logic [FILE_AW-1:0] faddr_nxt;

  logic [7:0] watchdog_counter_r;
  logic [7:0] watchdog_counter_nxt;
  logic [7:0] presc_r;
  logic [7:0] presc_nxt;

  logic wr_done;
  logic rd_phase;
  logic addr_known;
  logic [11:0] instr;
  logic rotate_left_carry_op;
  logic rotate_right_carry_op;
  logic sleep_op;
  logic exec_rotate;
  logic exec_sleep;
  logic [FILE_AW-1:0] mem_rd_addr;
  logic [DATA_W-1:0] mem_rd_data;
  logic mem_wr_en;
  logic [FILE_AW-1:0] mem_wr_addr;
  logic [DATA_W-1:0] mem_wr_data;
  logic [DATA_W-1:0] rot_result;
  logic rot_carry;
  logic [7:0] status_byte;

  ////////////////////////////////////////////////////////////////////////
  // decode

  assign instr = PWDATA[11:0];
  assign rotate_left_carry_op = instr[RSIE_OP_HI:RSIE_OP_LO] == RSIE_OPC_ROT_LEFT;
  assign rotate_right_carry_op = instr[RSIE_OP_HI:RSIE_OP_LO] == RSIE_OPC_ROT_RIGHT;
  assign sleep_op = instr == RSIE_OPC_SLEEP;

  // a write takes effect only at the edge where pready is seen high
  assign wr_done = (bus_r == RSIE_BUS_DONE) && PSEL && PENABLE && PWRITE;
  assign rd_phase = (bus_r == RSIE_BUS_WAIT);

  // a halted core ignores opcodes; only the wake register brings it back
  assign exec_rotate = wr_done && (PADDR == RSIE_OFS_INSTR) && !sleep_r
                       && (rotate_left_carry_op || rotate_right_carry_op);
  assign exec_sleep = wr_done && (PADDR == RSIE_OFS_INSTR) && !sleep_r && sleep_op;

  always_comb
  begin
    unique case (PADDR)
      RSIE_OFS_INSTR, RSIE_OFS_WREG, RSIE_OFS_STATUS, RSIE_OFS_WDOG,
      RSIE_OFS_PRESC, RSIE_OFS_FADDR, RSIE_OFS_FDATA, RSIE_OFS_WAKE:
        addr_known = 1'b1;
      default:
        addr_known = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // file registers and rotator

  // the operand address comes straight from the opcode so that the
  // registered read is ready during the wait cycle of the same transfer
  always_comb
  begin
    if (PWRITE && (PADDR == RSIE_OFS_INSTR))
    begin
      mem_rd_addr = instr[RSIE_FSEL_HI:0];
    end
    else
    begin
      mem_rd_addr = faddr_r;
    end
  end

  always_comb
  begin
    mem_wr_en = 1'b0;
    mem_wr_addr = faddr_r;
    mem_wr_data = PWDATA[DATA_W-1:0];
    if (exec_rotate && instr[RSIE_DEST_BIT])
    begin
      mem_wr_en = 1'b1; // RQ3
      mem_wr_addr = instr[RSIE_FSEL_HI:0];
      mem_wr_data = rot_result;
    end
    else if (wr_done && (PADDR == RSIE_OFS_FDATA))
    begin
      mem_wr_en = 1'b1;
    end
  end

  rsie_file_mem #(
    .DATA_W(DATA_W),
    .DEPTH(FILE_DEPTH),
    .ADDR_W(FILE_AW)
  ) rsie_file_mem_inst (
    .clk(CLK_SYS),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(mem_rd_addr),
    .rd_data_r(mem_rd_data)
  );

  rsie_rotate #(
    .DATA_W(DATA_W)
  ) rsie_rotate_inst (
    .data_in(mem_rd_data),
    .carry_in(carry_r),
    .rot_left(rotate_left_carry_op), // RQ1 RQ2
    .data_out(rot_result),
    .carry_out(rot_carry)
  );

  ////////////////////////////////////////////////////////////////////////
  // core state

  always_comb
  begin
    w_nxt = w_r;
    carry_nxt = carry_r;
    watchdog_expiry_flag_n_nxt = watchdog_expiry_flag_n_r;
    sleep_entered_flag_n_nxt = sleep_entered_flag_n_r;
    pin_change_wake_flag_nxt = pin_change_wake_flag_r;
    sleep_nxt = sleep_r;
    faddr_nxt = faddr_r;
    if (exec_rotate)
    begin
      // only carry moves among the status bits
      carry_nxt = rot_carry; // RQ1 RQ2 RQ8
      if (!instr[RSIE_DEST_BIT])
      begin
        w_nxt = rot_result; // RQ3
      end
    end
    else if (exec_sleep)
    begin
      watchdog_expiry_flag_n_nxt = 1'b1; // RQ4
      sleep_entered_flag_n_nxt = 1'b0; // RQ5
      sleep_nxt = 1'b1; // RQ7 RQ8
    end
    else if (wr_done)
    begin
      unique case (PADDR)
        RSIE_OFS_WREG:
          w_nxt = PWDATA[DATA_W-1:0];
        RSIE_OFS_STATUS:
        begin
          carry_nxt = PWDATA[RSIE_ST_CARRY];
          pin_change_wake_flag_nxt = PWDATA[RSIE_ST_WAKE];
        end
        RSIE_OFS_FADDR:
          faddr_nxt = PWDATA[FILE_AW-1:0];
        RSIE_OFS_WAKE:
          sleep_nxt = 1'b0;
        default:
          sleep_nxt = sleep_r;
      endcase
    end
  end

  // oscillator follows the halt one edge later, both as flops on pins
  assign osc_run_nxt = !sleep_r; // RQ7

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      w_r <= RSIE_W_RST;
      carry_r <= RSIE_CARRY_RST;
      watchdog_expiry_flag_n_r <= RSIE_EXPIRY_N_RST;
      sleep_entered_flag_n_r <= RSIE_SLEEP_N_RST;
      pin_change_wake_flag_r <= RSIE_WAKE_RST;
      sleep_r <= 1'b0;
      osc_run_r <= 1'b1;
      faddr_r <= RSIE_FADDR_RST;
    end
    else
    begin
      w_r <= w_nxt;
      carry_r <= carry_nxt;
      watchdog_expiry_flag_n_r <= watchdog_expiry_flag_n_nxt;
      sleep_entered_flag_n_r <= sleep_entered_flag_n_nxt;
      pin_change_wake_flag_r <= pin_change_wake_flag_nxt;
      sleep_r <= sleep_nxt;
      osc_run_r <= osc_run_nxt;
      faddr_r <= faddr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog counter and prescaler

  // free running: the real timer has its own oscillator and keeps going
  // in sleep, so it is not gated by the halt
  always_comb
  begin
    presc_nxt = presc_r + 8'h01;
    watchdog_counter_nxt = watchdog_counter_r;
    if (&presc_r)
    begin
      watchdog_counter_nxt = watchdog_counter_r + 8'h01;
    end
    if (exec_sleep)
    begin
      presc_nxt = RSIE_PRESC_CLEAR; // RQ6
      watchdog_counter_nxt = RSIE_WDOG_CLEAR; // RQ6
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      presc_r <= RSIE_PRESC_RST;
      watchdog_counter_r <= RSIE_WDOG_RST;
    end
    else
    begin
      presc_r <= presc_nxt;
      watchdog_counter_r <= watchdog_counter_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave: setup, one wait cycle for the file read, then ready

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[RSIE_ST_CARRY] = carry_r;
    status_byte[RSIE_ST_SLEEP_N] = sleep_entered_flag_n_r;
    status_byte[RSIE_ST_EXPIRY_N] = watchdog_expiry_flag_n_r;
    status_byte[RSIE_ST_WAKE] = pin_change_wake_flag_r;
  end

  always_comb
  begin
    bus_nxt = bus_r;
    unique case (bus_r)
      RSIE_BUS_IDLE:
        if (PSEL && !PENABLE)
        begin
          bus_nxt = RSIE_BUS_WAIT;
        end
      RSIE_BUS_WAIT:
        bus_nxt = RSIE_BUS_DONE;
      RSIE_BUS_DONE:
        bus_nxt = RSIE_BUS_IDLE;
      default:
        bus_nxt = RSIE_BUS_IDLE;
    endcase
  end

  always_comb
  begin
    pready_nxt = rd_phase;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h00000000;
    if (rd_phase)
    begin
      pslverr_nxt = !addr_known
                    || (PWRITE && (PADDR == RSIE_OFS_INSTR) && sleep_r);
      if (!PWRITE)
      begin
        unique case (PADDR)
          RSIE_OFS_WREG:
            prdata_nxt = {24'h000000, w_r};
          RSIE_OFS_STATUS:
            prdata_nxt = {24'h000000, status_byte};
          RSIE_OFS_WDOG:
            prdata_nxt = {24'h000000, watchdog_counter_r};
          RSIE_OFS_PRESC:
            prdata_nxt = {24'h000000, presc_r};
          RSIE_OFS_FADDR:
            prdata_nxt = {27'h0000000, faddr_r};
          RSIE_OFS_FDATA:
            prdata_nxt = {24'h000000, mem_rd_data};
          RSIE_OFS_WAKE:
            prdata_nxt = {31'h00000000, sleep_r};
          default:
            prdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      bus_r <= RSIE_BUS_IDLE;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else
    begin
      bus_r <= bus_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign PRDATA = prdata_r;
  assign PREADY = pready_r;
  assign PSLVERR = pslverr_r;
  assign SLEEP_ACTIVE = sleep_r;
  assign OSC_RUN = osc_run_r;

endmodule

// ===== tb/rsie_core_properties.sv
// concurrent checks on the ports of the rotate / sleep execution block
// assumes one clock, synchronous active-high reset, apb on the slave side
`timescale 1ns/1ns
module rsie_core_properties
  import rsie_pkg::*;
(
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // power state
  input wire logic SLEEP_ACTIVE,
  input wire logic OSC_RUN
);
  logic xfer;
  logic instr_wr;
  assign xfer = PSEL && PENABLE && PREADY;
  assign instr_wr = xfer && PWRITE && PADDR == RSIE_OFS_INSTR;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready over one cycle");

  // two-cycle access phase, so one opcode per transfer
  property p_ready_lat;
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |-> !PREADY ##1 PREADY;
  endproperty
  a_ready_lat: assert property (p_ready_lat) else $error("pready early or late");

  property p_sleep_go;
    instr_wr && PWDATA[11:0] == RSIE_OPC_SLEEP && !SLEEP_ACTIVE |=> SLEEP_ACTIVE;
  endproperty
  a_sleep_go: assert property (p_sleep_go) else $error("sleep opcode did not halt");

  property p_sleep_cause;
    $rose(SLEEP_ACTIVE) |-> $past(instr_wr);
  endproperty
  a_sleep_cause: assert property (p_sleep_cause) else $error("halt without sleep opcode");

  property p_osc_stop;
    $rose(SLEEP_ACTIVE) |=> !OSC_RUN;
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillator kept running");

  property p_osc_held;
    SLEEP_ACTIVE ##1 SLEEP_ACTIVE |-> !OSC_RUN;
  endproperty
  a_osc_held: assert property (p_osc_held) else $error("oscillator ran while asleep");

  property p_osc_back;
    $fell(SLEEP_ACTIVE) |=> OSC_RUN;
  endproperty
  a_osc_back: assert property (p_osc_back) else $error("oscillator not restarted");

  // a halted core must refuse further opcodes
  property p_halted;
    instr_wr && SLEEP_ACTIVE |-> PSLVERR;
  endproperty
  a_halted: assert property (p_halted) else $error("opcode accepted while asleep");

  property p_flags_asleep;
    xfer && !PWRITE && PADDR == RSIE_OFS_STATUS && SLEEP_ACTIVE
      |-> PRDATA[RSIE_ST_EXPIRY_N] && !PRDATA[RSIE_ST_SLEEP_N];
  endproperty
  a_flags_asleep: assert property (p_flags_asleep) else $error("sleep status wrong");

  property p_idle_zero;
    !PREADY |-> PRDATA == 32'h0 && !PSLVERR;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside transfer");
endmodule

bind rsie_core rsie_core_properties rsie_core_properties_inst (.CLK_SYS(CLK_SYS), .RST(RST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SLEEP_ACTIVE(SLEEP_ACTIVE),
  .OSC_RUN(OSC_RUN));

// ===== tb/tb_rsie_core.sv
// self-checking bench for the rotate / sleep execution block
// assumes the block answers every apb transfer with a one-cycle pready
`timescale 1ns/1ns
module tb_rsie_core;
  import rsie_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic SLEEP_ACTIVE;
  logic OSC_RUN;
  logic [31:0] rdat;
  logic rerr;
  int failures = 0;
  int compares = 0;

  always #5 CLK_SYS = ~CLK_SYS;

  rsie_core rsie_core_inst (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SLEEP_ACTIVE(SLEEP_ACTIVE), .OSC_RUN(OSC_RUN));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (failures == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // request held until pready is sampled high, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge CLK_SYS);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      test_done();
    end
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic reset_state;
    apb(0, RSIE_OFS_STATUS, 32'h0);
    chk("status", 32'h18, rdat);
    chk("sleep_rst", 32'h0, {31'h0, SLEEP_ACTIVE});
    chk("osc_rst", 32'h1, {31'h0, OSC_RUN});
    apb(0, RSIE_OFS_WREG, 32'h0);
    chk("wreg", 32'h0, rdat);
    apb(0, 8'h20, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, rerr});
    chk("unmapped_data", 32'h0, rdat);
  endtask

  // one rotate, result compared with a shift worked out here
  task automatic rot(input logic l, input logic d, input logic [4:0] f, input logic [7:0] v,
    input logic c);
    logic [7:0] r;
    logic co;
    r = l ? {v[6:0], c} : {c, v[7:1]};
    co = l ? v[7] : v[0];
    apb(1, RSIE_OFS_FADDR, {27'h0, f});
    apb(1, RSIE_OFS_FDATA, {24'h0, v});
    apb(1, RSIE_OFS_STATUS, {31'h0, c});
    apb(1, RSIE_OFS_WREG, 32'h5A);
    apb(1, RSIE_OFS_INSTR, {20'h0, l ? RSIE_OPC_ROT_LEFT : RSIE_OPC_ROT_RIGHT, d, f});
    chk("instr_err", 32'h0, {31'h0, rerr});
    apb(0, RSIE_OFS_WREG, 32'h0);
    chk("wreg", {24'h0, d ? 8'h5A : r}, rdat);
    apb(0, RSIE_OFS_FDATA, 32'h0);
    chk("fdata", {24'h0, d ? r : v}, rdat);
    apb(0, RSIE_OFS_STATUS, 32'h0);
    chk("status", {24'h0, 7'h0C, co}, rdat);
  endtask

  task automatic sleep_cycle;
    apb(1, RSIE_OFS_STATUS, 32'h81);
    repeat (600) @(posedge CLK_SYS);
    apb(0, RSIE_OFS_WDOG, 32'h0);
    chk("wdog_running", 32'h1, {31'h0, rdat != 32'h0});
    apb(1, RSIE_OFS_INSTR, {20'h0, RSIE_OPC_SLEEP});
    @(posedge CLK_SYS);
    chk("sleep", 32'h1, {31'h0, SLEEP_ACTIVE});
    @(posedge CLK_SYS);
    chk("osc", 32'h0, {31'h0, OSC_RUN});
    apb(0, RSIE_OFS_WDOG, 32'h0);
    chk("wdog", 32'h0, rdat);
    apb(0, RSIE_OFS_PRESC, 32'h0);
    chk("presc_low", 32'h1, {31'h0, rdat < 32'h10});
    apb(0, RSIE_OFS_STATUS, 32'h0);
    chk("status", 32'h91, rdat);
    // halted core refuses the next opcode
    apb(1, RSIE_OFS_INSTR, {20'h0, RSIE_OPC_ROT_LEFT, 1'b0, 5'h00});
    chk("halt_err", 32'h1, {31'h0, rerr});
    apb(0, RSIE_OFS_WREG, 32'h0);
    chk("wreg", 32'h5A, rdat);
    apb(1, RSIE_OFS_WAKE, 32'h0);
    @(posedge CLK_SYS);
    chk("wake", 32'h0, {31'h0, SLEEP_ACTIVE});
    @(posedge CLK_SYS);
    chk("osc", 32'h1, {31'h0, OSC_RUN});
  endtask

  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RST <= 1'b0;
    reset_state();
    rot(1'b1, 1'b0, 5'h03, 8'hE6, 1'b0);
    rot(1'b0, 1'b0, 5'h03, 8'hE6, 1'b0);
    rot(1'b1, 1'b1, 5'h1F, 8'h81, 1'b1);
    rot(1'b0, 1'b1, 5'h00, 8'h01, 1'b1);
    sleep_cycle();
    test_done();
  end
endmodule
